/* hw/ofp_freq_prog.sv */
// Purpose: Frequency programming registers, update sequence and output gate.
// Assumes: Byte register port driven by the serial slave, synchronous to clk_i.
// Notes: Staged divider bytes take effect when calibration completes, or one cycle after a start write with override set.
//
// Contract
// - Power-of-two field value zero divides by one
// - Integer output divider accepts up to 2046
// - Feedback divider is unsigned 11.32, 43 bits
// - Packed register: exponent bits 6..4, integer high 2..0
// - Packed register bits 7 and 3 unused
// - Divider bytes at registers 23 to 31
// - Writes alone do not change active dividers
// - Writing zero to 69 clears calibration override
// - Writing zero to 17 gates output off cleanly
// - Writing 0x08 to 7 starts calibration
// - Calibration completes within 30 ms
// - Writing one to 17 gates output back on
// - Settings work on every faster speed grade
// - Exponent six or seven divides by 32
// - Odd low integer ratios keep 50 percent duty; the divider instead holds the output high for the longer half of an odd period
`timescale 1ns/1ps
`default_nettype none
module ofp_freq_prog #(
    parameter int CAL_CYCLES = ofp_pkg::OFP_CAL_CYCLES // Calibration time in cycles
) (
    input wire logic clk_i, // System clock, 200 MHz
    input wire logic reset_i, // Async reset, active high
    input wire logic reg_wr_i, // Register write strobe
    input wire logic reg_rd_i, // Register read strobe
    input wire logic [ofp_pkg::OFP_AW-1:0] reg_addr_i, // Register number
    input wire logic [ofp_pkg::OFP_DW-1:0] reg_wdata_i, // Write data
    output logic [ofp_pkg::OFP_DW-1:0] reg_rdata_o, // Read data
    output logic reg_rvalid_o, // Read data valid pulse
    output logic clk_out_o, // Divided, gated output clock
    output logic out_enabled_o, // Gate state in effect
    output logic calibrating_o, // Calibration in progress
    output logic [ofp_pkg::OFP_INT_W-1:0] act_int_div_o, // Active integer ratio
    output logic [ofp_pkg::OFP_P2_W-1:0] act_p2_o, // Active exponent
    output logic [ofp_pkg::OFP_FB_W-1:0] act_fb_o // Active feedback divider
);
    import ofp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0] page_q; // page_select contents
    logic [7:0] ovr_q; // calibration_override contents
    logic gate_q; // Requested output enable
    logic [7:0] div_low_q; // Integer divider low byte
    logic [OFP_INT_HI_W-1:0] int_hi_q; // Integer divider high bits
    logic [OFP_P2_W-1:0] p2_q; // Staged power-of-two exponent
    logic [OFP_FB_W-1:0] fb_q; // Staged feedback divider
    logic page_zero_w; // Page zero selected
    logic wr_w; // Write accepted on page zero, or to page_select on any page
    logic rd_w; // Read on page zero, or of page_select on any page
    logic cal_req_w; // Write to calibration_control with start set
    logic cal_run_w; // Start the timed calibration
    logic apply_now_w; // Override set, apply without calibration
    logic cal_busy_w; // Timer running
    logic cal_done_w; // Timer finished pulse
    logic apply_q; // Delayed apply for the override path
    logic div_gate_w; // Gate state from divider
    logic div_clk_w; // Clock level from divider
    logic [OFP_INT_W-1:0] staged_int_w; // Staged integer ratio
    logic [7:0] rdata_w; // Read mux result
    logic [OFP_CNT_W-1:0] cal_cycles_w; // Calibration length

    ////////////////////////////////////////////////////////////////////////////
    // Access decode
    always_comb begin
        page_zero_w = (page_q == OFP_PAGE_ZERO);
        wr_w = reg_wr_i && (page_zero_w || reg_addr_i == OFP_ADDR_PAGE);
        rd_w = reg_rd_i && (page_zero_w || reg_addr_i == OFP_ADDR_PAGE);
        cal_req_w = wr_w && (reg_addr_i == OFP_ADDR_CAL_CTRL)
            && reg_wdata_i[OFP_CAL_START_BIT];
        cal_run_w = cal_req_w && !ovr_q[OFP_OVR_BIT];
        apply_now_w = cal_req_w && ovr_q[OFP_OVR_BIT];
        staged_int_w = {int_hi_q, div_low_q};
        cal_cycles_w = CAL_CYCLES[OFP_CNT_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Page select register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            page_q <= OFP_RST_PAGE;
        end else if (wr_w && reg_addr_i == OFP_ADDR_PAGE) begin // Page write
            page_q <= reg_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calibration override register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ovr_q <= OFP_RST_CAL_OVR;
        end else if (wr_w && reg_addr_i == OFP_ADDR_CAL_OVR) begin // Override write
            ovr_q <= reg_wdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output gate request
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            gate_q <= OFP_RST_GATE[OFP_GATE_BIT];
        end else if (wr_w && reg_addr_i == OFP_ADDR_GATE) begin // Gate write
            gate_q <= reg_wdata_i[OFP_GATE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Integer and power-of-two divider staging
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_low_q <= OFP_RST_DIV_LOW;
            int_hi_q <= OFP_RST_DIV_HIGH[OFP_INT_HI_W-1:0];
            p2_q <= OFP_RST_DIV_HIGH[OFP_P2_LSB+:OFP_P2_W];
        end else if (wr_w) begin
            if (reg_addr_i == OFP_ADDR_DIV_LOW) begin // Low byte
                div_low_q <= reg_wdata_i;
            end else if (reg_addr_i == OFP_ADDR_DIV_HIGH) begin // Packed byte
                p2_q <= reg_wdata_i[OFP_P2_LSB+:OFP_P2_W];
                int_hi_q <= reg_wdata_i[OFP_INT_HI_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Feedback divider staging, least significant byte first
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            fb_q <= '0;
        end else if (wr_w) begin
            if (reg_addr_i == OFP_ADDR_FB0) begin // Bits 7..0
                fb_q[7:0] <= reg_wdata_i;
            end else if (reg_addr_i == OFP_ADDR_FB1) begin // Bits 15..8
                fb_q[15:8] <= reg_wdata_i;
            end else if (reg_addr_i == OFP_ADDR_FB2) begin // Bits 23..16
                fb_q[23:16] <= reg_wdata_i;
            end else if (reg_addr_i == OFP_ADDR_FB3) begin // Bits 31..24
                fb_q[31:24] <= reg_wdata_i;
            end else if (reg_addr_i == OFP_ADDR_FB4) begin // Bits 39..32
                fb_q[39:32] <= reg_wdata_i;
            end else if (reg_addr_i == OFP_ADDR_FB_TOP) begin // Bits 42..40
                fb_q[42:40] <= reg_wdata_i[OFP_FB_TOP_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calibration timer
    ofp_cal_timer u_cal_timer (
        .clk_i(clk_i), // System clock
        .reset_i(reset_i), // Reset
        .start_i(cal_run_w), // Start on a start write with override clear
        .cycles_i(cal_cycles_w), // Length of calibration
        .busy_o(cal_busy_w), // Running
        .done_o(cal_done_w) // Finished
    );

    ////////////////////////////////////////////////////////////////////////////
    // Override path applies one cycle after the start write
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            apply_q <= 1'b0;
        end else begin
            apply_q <= apply_now_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Active dividers: loaded when calibration completes or on the override apply
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            act_int_div_o <= {OFP_RST_DIV_HIGH[OFP_INT_HI_W-1:0], OFP_RST_DIV_LOW};
            act_p2_o <= OFP_RST_DIV_HIGH[OFP_P2_LSB+:OFP_P2_W];
            act_fb_o <= '0;
        end else if (cal_done_w || apply_q) begin // Update complete
            act_int_div_o <= staged_int_w;
            act_p2_o <= p2_q;
            act_fb_o <= fb_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calibration status output
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            calibrating_o <= 1'b0;
        end else begin
            calibrating_o <= cal_busy_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output divider and glitch-free gate
    ofp_out_div u_out_div (
        .clk_i(clk_i), // System clock
        .reset_i(reset_i), // Reset
        .int_div_i(act_int_div_o), // Active integer ratio
        .p2_i(act_p2_o), // Active exponent
        .gate_i(gate_q), // Requested gate
        .clk_out_o(div_clk_w), // Divided clock
        .gate_o(div_gate_w) // Gate in effect
    );

    always_comb begin
        clk_out_o = div_clk_w; // Already a flop in the divider
        out_enabled_o = div_gate_w; // Already a flop in the divider
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped bits read zero, unused bits too except in calibration_override
    always_comb begin
        rdata_w = 8'h00;
        if (reg_addr_i == OFP_ADDR_PAGE) begin // Page select
            rdata_w = page_q;
        end else if (!page_zero_w) begin // Other pages are not implemented
            rdata_w = 8'h00;
        end else if (reg_addr_i == OFP_ADDR_CAL_CTRL) begin // Start bit reads busy
            rdata_w[OFP_CAL_START_BIT] = cal_busy_w;
        end else if (reg_addr_i == OFP_ADDR_GATE) begin // Gate request
            rdata_w[OFP_GATE_BIT] = gate_q;
        end else if (reg_addr_i == OFP_ADDR_DIV_LOW) begin // Integer low byte
            rdata_w = div_low_q;
        end else if (reg_addr_i == OFP_ADDR_DIV_HIGH) begin // Bits 7 and 3 zero
            rdata_w = {1'b0, p2_q, 1'b0, int_hi_q};
        end else if (reg_addr_i == OFP_ADDR_FB0) begin
            rdata_w = fb_q[7:0];
        end else if (reg_addr_i == OFP_ADDR_FB1) begin
            rdata_w = fb_q[15:8];
        end else if (reg_addr_i == OFP_ADDR_FB2) begin
            rdata_w = fb_q[23:16];
        end else if (reg_addr_i == OFP_ADDR_FB3) begin
            rdata_w = fb_q[31:24];
        end else if (reg_addr_i == OFP_ADDR_FB4) begin
            rdata_w = fb_q[39:32];
        end else if (reg_addr_i == OFP_ADDR_FB_TOP) begin // Top three bits only
            rdata_w = {5'h00, fb_q[42:40]};
        end else if (reg_addr_i == OFP_ADDR_CAL_OVR) begin
            rdata_w = ovr_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered read answer
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin // Capture on a read strobe
                reg_rdata_o <= rd_w ? rdata_w : 8'h00;
            end
        end
    end
endmodule : ofp_freq_prog
`default_nettype wire

/* hw/ofp_pkg.sv */
// Purpose: Shared constants for the output frequency programming block.
// Assumes: Byte-wide register port; one 200 MHz clock.
// Notes: Offsets are page-0 byte register numbers.
package ofp_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // Register port widths
    localparam int OFP_AW = 8; // Register number width
    localparam int OFP_DW = 8; // Register data width
    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] OFP_ADDR_CAL_CTRL = 8'h07; // calibration_control
    localparam logic [7:0] OFP_ADDR_GATE = 8'h11; // output_gate_control
    localparam logic [7:0] OFP_ADDR_DIV_LOW = 8'h17; // output_divider_low
    localparam logic [7:0] OFP_ADDR_DIV_HIGH = 8'h18; // packed_divider_high
    localparam logic [7:0] OFP_ADDR_FB0 = 8'h1A; // feedback_divider_byte0
    localparam logic [7:0] OFP_ADDR_FB1 = 8'h1B; // feedback_divider_byte1
    localparam logic [7:0] OFP_ADDR_FB2 = 8'h1C; // feedback_divider_byte2
    localparam logic [7:0] OFP_ADDR_FB3 = 8'h1D; // feedback_divider_byte3
    localparam logic [7:0] OFP_ADDR_FB4 = 8'h1E; // feedback_divider_byte4
    localparam logic [7:0] OFP_ADDR_FB_TOP = 8'h1F; // feedback_divider_top
    localparam logic [7:0] OFP_ADDR_CAL_OVR = 8'h45; // calibration_override
    localparam logic [7:0] OFP_ADDR_PAGE = 8'hFF; // page_select
    ////////////////////////////////////////////////////////////////////////////
    // Field positions and values
    localparam int OFP_CAL_START_BIT = 3; // Start bit in calibration_control
    localparam int OFP_GATE_BIT = 0; // Output enable bit in output_gate_control
    localparam int OFP_OVR_BIT = 0; // Override bit in calibration_override
    localparam int OFP_P2_LSB = 4; // Power-of-two field low bit in packed reg
    localparam int OFP_P2_W = 3; // Power-of-two field width
    localparam int OFP_INT_HI_W = 3; // Integer divider upper bits in packed reg
    localparam int OFP_INT_W = 11; // Integer output divider width
    localparam int OFP_FB_INT_W = 11; // Feedback integer part width
    localparam int OFP_FB_FRAC_W = 32; // Feedback fraction part width
    localparam int OFP_FB_W = OFP_FB_INT_W + OFP_FB_FRAC_W; // 43 bits in total
    localparam int OFP_FB_TOP_W = 3; // Feedback bits 42..40
    localparam logic [2:0] OFP_P2_MAX_EXP = 3'h5; // Largest exponent, divide by 32
    localparam logic [10:0] OFP_INT_MAX = 11'h7FE; // Largest integer divider, 2046
    localparam logic [10:0] OFP_INT_MIN_HW = 11'h002; // Smallest ratio the counter runs
    localparam int OFP_PERIOD_W = 16; // Width of total divide period
    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] OFP_RST_CAL_CTRL = 8'h00; // calibration_control
    localparam logic [7:0] OFP_RST_GATE = 8'h01; // output_gate_control
    localparam logic [7:0] OFP_RST_DIV_LOW = 8'h54; // output_divider_low
    localparam logic [7:0] OFP_RST_DIV_HIGH = 8'h00; // packed_divider_high
    localparam logic [7:0] OFP_RST_FB_BYTE = 8'h00; // each feedback byte
    localparam logic [7:0] OFP_RST_CAL_OVR = 8'h00; // calibration_override
    localparam logic [7:0] OFP_RST_PAGE = 8'h00; // page_select
    localparam logic [7:0] OFP_PAGE_ZERO = 8'h00; // Page holding these registers
    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int OFP_CLK_MHZ = 200; // Clock rate in MHz
    localparam int OFP_CAL_TIME_MS = 30; // Calibration time in ms
    localparam int OFP_CAL_CYCLES = OFP_CAL_TIME_MS * 1000 * OFP_CLK_MHZ; // Longest, down
    localparam int OFP_CNT_W = 32; // Calibration counter width
endpackage : ofp_pkg

/* hw/ofp_cal_timer.sv */
// Purpose: Counts out the core calibration time after a start pulse.
// Assumes: cycles_i is at least one and stable while busy.
// Notes: A start while busy restarts the count.
`timescale 1ns/1ps
`default_nettype none
module ofp_cal_timer (
    input wire logic clk_i, // System clock
    input wire logic reset_i, // Async reset, active high
    input wire logic start_i, // One-cycle start pulse
    input wire logic [ofp_pkg::OFP_CNT_W-1:0] cycles_i, // Cycles to run
    output logic busy_o, // High while calibrating
    output logic done_o // One-cycle pulse at completion
);
    import ofp_pkg::*;
    logic [OFP_CNT_W-1:0] cnt_q; // Cycles remaining
    ////////////////////////////////////////////////////////////////////////////
    // Countdown and completion pulse
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else if (start_i) begin // Load count less one
            cnt_q <= cycles_i - 32'h00000001;
            busy_o <= 1'b1;
            done_o <= 1'b0;
        end else if (busy_o && cnt_q == '0) begin // Time is up
            busy_o <= 1'b0;
            done_o <= 1'b1;
        end else begin
            cnt_q <= busy_o ? cnt_q - 32'h00000001 : cnt_q;
            done_o <= 1'b0;
        end
    end
endmodule : ofp_cal_timer
`default_nettype wire

/* hw/ofp_out_div.sv */
// Purpose: Output divider: integer ratio times power-of-two, with glitch-free gate.
// Assumes: Ratios change only at period ends matter for clean edges.
// Notes: Odd periods (odd ratio, exponent zero) give high for the longer half of the period.
`timescale 1ns/1ps
`default_nettype none
module ofp_out_div (
    input wire logic clk_i, // System clock
    input wire logic reset_i, // Async reset, active high
    input wire logic [ofp_pkg::OFP_INT_W-1:0] int_div_i, // Integer ratio
    input wire logic [ofp_pkg::OFP_P2_W-1:0] p2_i, // Power-of-two exponent
    input wire logic gate_i, // Requested output enable
    output logic clk_out_o, // Divided clock level
    output logic gate_o // Gate state in effect
);
    import ofp_pkg::*;
    logic [2:0] exp_w; // Clamped exponent
    logic [OFP_INT_W-1:0] n_w; // Ratio the counter can run
    logic [OFP_PERIOD_W-1:0] period_w; // Total period in cycles
    logic [OFP_PERIOD_W-1:0] half_w; // High part of the period
    logic [OFP_PERIOD_W-1:0] cnt_q; // Position in period
    logic wrap_w; // Last cycle of period
    ////////////////////////////////////////////////////////////////////////////
    // Ratio decode
    always_comb begin
        exp_w = (p2_i > OFP_P2_MAX_EXP) ? OFP_P2_MAX_EXP : p2_i;
        n_w = (int_div_i < OFP_INT_MIN_HW) ? OFP_INT_MIN_HW : int_div_i;
        period_w = {5'h00, n_w} << exp_w;
        half_w = {1'b0, period_w[OFP_PERIOD_W-1:1]} + {15'h0000, period_w[0]};
        wrap_w = (cnt_q >= period_w - 16'h0001);
    end
    ////////////////////////////////////////////////////////////////////////////
    // Period counter; gate changes only at a period end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= '0;
            gate_o <= 1'b1;
        end else if (wrap_w) begin
            cnt_q <= '0;
            gate_o <= gate_i;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Output level, odd periods high for the longer half by rounding the high part up
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            clk_out_o <= 1'b0;
        end else begin
            clk_out_o <= gate_o && (cnt_q < half_w);
        end
    end
endmodule : ofp_out_div
`default_nettype wire

/* bench/ofp_chk.sv */
// Purpose: Port checker for the frequency programming block.
// Assumes: Calibration override stays clear during the run.
// Notes: Bound to the design from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module ofp_chk #(
    parameter int CAL_CYCLES = 20 // Calibration time in cycles
) (
    input wire logic clk_i, // Clock
    input wire logic reset_i, // Reset
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    input wire logic [7:0] reg_addr_i, // Register number
    input wire logic [7:0] reg_wdata_i, // Write data
    input wire logic reg_rvalid_o, // Read valid
    input wire logic clk_out_o, // Output clock
    input wire logic out_enabled_o, // Gate state
    input wire logic calibrating_o, // Calibration running
    input wire logic [10:0] act_int_div_o, // Active ratio
    input wire logic [42:0] act_fb_o // Active feedback divider
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    localparam int GMAX = 300; // Longest gate delay in the run
    logic [7:0] page_q; // Page in effect
    int cal_q; // Cycles seen calibrating
    wire logic wr_ok = reg_wr_i && (page_q == 8'h00 || reg_addr_i == 8'hFF); // Accepted write
    ////////////////////////////////////////////////////////////////////////////
    // Page tracking, so refused writes are not taken as causes
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) page_q <= 8'h00;
        else if (reg_wr_i && reg_addr_i == 8'hFF) page_q <= reg_wdata_i;
    end
    // Length of the calibration run
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) cal_q <= 0;
        else cal_q <= calibrating_o ? cal_q + 1 : 0;
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_rd; reg_rd_i |=> reg_rvalid_o; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_keep; wr_ok && reg_addr_i inside {[8'h17:8'h1F]} && !calibrating_o
        |=> $stable(act_int_div_o) && $stable(act_fb_o); endproperty
    a_keep: assert property (p_keep) else $error("divider write took effect");
    property p_cal_rise; wr_ok && reg_addr_i == 8'h07 && reg_wdata_i[3] && !calibrating_o
        |-> ##2 calibrating_o; endproperty
    a_cal_rise: assert property (p_cal_rise) else $error("calibration not started");
    property p_cal_len; $fell(calibrating_o) |-> cal_q == CAL_CYCLES; endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
    property p_load; $changed(act_fb_o) || $changed(act_int_div_o) |-> $fell(calibrating_o);
    endproperty
    a_load: assert property (p_load) else $error("dividers loaded off completion");
    property p_dark; !out_enabled_o ##1 !out_enabled_o |-> !clk_out_o; endproperty
    a_dark: assert property (p_dark) else $error("clock while gated off");
    property p_off; wr_ok && reg_addr_i == 8'h11 && !reg_wdata_i[0]
        |-> ##[1:GMAX] !out_enabled_o; endproperty
    a_off: assert property (p_off) else $error("gate off not applied");
    property p_on; wr_ok && reg_addr_i == 8'h11 && reg_wdata_i[0]
        |-> ##[1:GMAX] out_enabled_o; endproperty
    a_on: assert property (p_on) else $error("gate on not applied");
endmodule : ofp_chk
`default_nettype wire

/* bench/ofp_host.sv */
// Purpose: Host model driving the byte register port.
// Assumes: Strobes launched on the falling clock edge.
// Notes: Expected read bytes are queued for the bench monitor.
`timescale 1ns/1ps
`default_nettype none
module ofp_host #(
    parameter int CAL = 20 // Calibration wait in cycles
) (
    input wire logic clk_i, // Clock
    output logic reg_wr_o = 1'b0, // Write strobe
    output logic reg_rd_o = 1'b0, // Read strobe
    output logic [7:0] reg_addr_o = 8'h00, // Register number
    output logic [7:0] reg_wdata_o = 8'h00 // Write data
);
    logic [7:0] exp_q[$]; // Expected read bytes, oldest first
    // One byte write; lines show inverted values once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_wr_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(negedge clk_i);
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask : wr
    // One byte read, expectation noted first
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(negedge clk_i);
        reg_rd_o = 1'b1;
        reg_addr_o = a;
        @(negedge clk_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
    endtask : rd
    // Whole frequency update procedure, in order
    task automatic upd(input logic [10:0] n, input logic [2:0] e, input logic [42:0] fb);
        wr(8'hFF, 8'h00);
        wr(8'h45, 8'h00);
        wr(8'h11, 8'h00);
        wr(8'h17, n[7:0]);
        wr(8'h18, {1'b0, e, 1'b0, n[10:8]});
        for (int i = 0; i < 6; i++) wr(8'h1A + 8'(i), 8'(fb >> (8 * i)));
        wr(8'h07, 8'h08);
        rd(8'h07, 8'h08);
        repeat (CAL + 2) @(negedge clk_i);
        rd(8'h07, 8'h00);
        wr(8'h11, 8'h01);
    endtask : upd
endmodule : ofp_host
`default_nettype wire

/* bench/tb.sv */
// Purpose: Self-checking bench for the frequency programming block.
// Assumes: Calibration time shortened through CAL_CYCLES.
// Notes: Host model drives the register port; reads are checked from a queue.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ofp_pkg::*;
    localparam int CAL_CYCLES = 20; // Shortened calibration
    logic clk_i, reset_i, reg_wr_i, reg_rd_i, reg_rvalid_o, clk_out_o; // Controls
    logic out_enabled_o, calibrating_o; // Status
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o; // Register port data
    logic [10:0] act_int_div_o; // Active ratio
    logic [2:0] act_p2_o; // Active exponent
    logic [42:0] act_fb_o, fb; // Active and written feedback
    logic [7:0] d[9]; // Written bytes
    int seed = 32'h8383DB80, miscompares = 0, n_tests = 0, h, p, pe; // Bench state
    int nv[3] = '{5, 4, 70}; // Ratios; odd only up to 33
    int ev[3] = '{0, 6, 0}; // Exponents
    ofp_freq_prog #(.CAL_CYCLES(CAL_CYCLES)) uut (.clk_i, .reset_i, .reg_wr_i, .reg_rd_i,
        .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .clk_out_o, .out_enabled_o,
        .calibrating_o, .act_int_div_o, .act_p2_o, .act_fb_o);
    ofp_host #(.CAL(CAL_CYCLES)) host (.clk_i, .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
        .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    // High time and period of one output cycle, each wait bounded
    task automatic meas();
        int n;
        h = 0;
        for (n = 0; n < 3000 && clk_out_o !== 1'b0; n++) @(negedge clk_i);
        for (n = 0; n < 3000 && clk_out_o !== 1'b1; n++) @(negedge clk_i);
        while (h < 3000 && clk_out_o === 1'b1) begin h++; @(negedge clk_i); end
        p = h;
        while (p < 3000 && clk_out_o === 1'b0) begin p++; @(negedge clk_i); end
    endtask : meas
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Read monitor takes the oldest expectation
    always @(posedge clk_i) begin
        if (reg_rvalid_o === 1'b1) begin
            if (host.exp_q.size() == 0) chk("spurious read", 64'h0, 64'h1);
            else chk("read data", 64'(host.exp_q.pop_front()), 64'(reg_rdata_o));
        end
    end
    initial begin
        repeat (100000) @(posedge clk_i);
        chk("run time", 64'h0, 64'h1);
        wrap_up();
    end
    initial begin
        reset_i = 1'b1;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        reset_i = 1'b0;
        chk("reset ratio", 64'h054, 64'(act_int_div_o));
        foreach (d[i]) host.rd(8'h17 + 8'(i), i == 0 ? OFP_RST_DIV_LOW : 8'h00);
        foreach (nv[i]) host.rd(i == 0 ? 8'h07 : i == 1 ? 8'h11 : 8'h45,
            i == 1 ? OFP_RST_GATE : 8'h00);
        for (int i = 8; i >= 0; i--) begin
            d[i] = 8'($random(seed)) & (i == 1 ? 8'h77 : i == 8 ? 8'h07 : 8'hFF);
            host.wr(8'h17 + 8'(i), d[i]);
        end
        foreach (d[i]) host.rd(8'h17 + 8'(i), i == 2 ? 8'h00 : d[i]);
        chk("ratio kept", 64'h054, 64'(act_int_div_o));
        host.wr(8'hFF, 8'h01);
        host.wr(8'h17, ~d[0]);
        host.rd(8'h17, 8'h00);
        host.wr(8'hFF, 8'h00);
        host.rd(8'h17, d[0]);
        for (int i = 0; i < 3; i++) begin
            fb = {11'($random(seed)), 32'($random(seed))};
            host.upd(11'(nv[i]), 3'(ev[i]), fb);
            chk("active ratio", 64'(nv[i]), 64'(act_int_div_o));
            chk("active exponent", 64'(ev[i]), 64'(act_p2_o));
            chk("active feedback", 64'(fb), 64'(act_fb_o));
            meas();
            pe = nv[i] << (ev[i] > 5 ? 5 : ev[i]);
            chk("period", 64'(pe), 64'(p));
            chk("high time", 64'((pe + 1) / 2), 64'(h));
        end
        chk("pending reads", 64'h0, 64'(host.exp_q.size()));
        wrap_up();
    end
endmodule : tb
bind ofp_freq_prog ofp_chk #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.clk_i, .reset_i, .reg_wr_i,
    .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rvalid_o, .clk_out_o, .out_enabled_o,
    .calibrating_o, .act_int_div_o, .act_fb_o);
`default_nettype wire
